// ### rtl/pc4_top.sv
/*
 * wishbone-reachable presettable four bit counter.
 * assumes a classic single-cycle wishbone master on clk_i (10 MHz) and
 * a synchronous active-high bus reset.
 */
// Added by the designer: the address map and the Wishbone slave port.
`default_nettype none
// Contract
// - four bit count with preset load, reset, carry and enables
// - count advances only on rising clock edges when enabled
// - load and synchronous reset act on the rising edge
// - preset bit 0 is lsb, bit 3 is msb
// - count outputs show the count, bit 0 lsb
// - carry high while count is 1111 and trickle enable is high
// - carry is trickle enable and all four count bits
// - low reset clears the count to zero
// - build option picks asynchronous or synchronous reset
// - low load copies preset into count on the edge
// - low load blocks counting whatever the enables
// - count only when both enables and load are high
// - trickle enable gates carry; parallel enable only counting
// - maximum wraps to zero on next enabled step
module pc4_top
   import pc4_pkg::*;
#(
   parameter pc4_rst_mode_t RST_MODE = PC4_RST_SYNC
) (
   input wire logic clk_i, // system clock
   input wire logic rst_i, // synchronous reset, high
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [7:0] wb_adr_i, // byte address
   input wire logic [3:0] wb_sel_i, // byte selects
   input wire logic [31:0] wb_dat_i, // write data
   output logic [31:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic [3:0] count_o, // count outputs
   output logic carry_o // terminal carry
);
   pc4_ctl_if ctl ();
   logic [3:0] ctrl_q;
   logic [3:0] preset_q;
   logic ack_q;
   logic [31:0] rdat_q;
   logic req;
   logic wr_lo;
   logic hit_ctrl;
   logic hit_preset;
   logic hit_count;
   logic hit_stat;
   logic [31:0] rdat_d;

   // request decode, one ack per request
   assign req = wb_cyc_i & wb_stb_i & !ack_q;
   assign wr_lo = req & wb_we_i & wb_sel_i[0];
   assign hit_ctrl = wb_adr_i == PC4_ADR_CTRL;
   assign hit_preset = wb_adr_i == PC4_ADR_PRESET;
   assign hit_count = wb_adr_i == PC4_ADR_COUNT;
   assign hit_stat = wb_adr_i == PC4_ADR_STAT;

   // read mux, unmapped reads return zero
   always_comb begin
      rdat_d = 32'h0000_0000;
      if (hit_ctrl) begin
         rdat_d[3:0] = ctrl_q;
      end else if (hit_preset) begin
         rdat_d[3:0] = preset_q;
      end else if (hit_count) begin
         rdat_d[3:0] = ctl.count;
      end else if (hit_stat) begin
         rdat_d[PC4_B_CARRY] = ctl.carry;
         rdat_d[PC4_B_ASYNC] = RST_MODE == PC4_RST_ASYNC;
      end
   end

   // ack and read data one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         rdat_q <= rdat_d;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= PC4_CTRL_RST;
         preset_q <= PC4_ZERO;
      end else if (wr_lo && hit_ctrl) begin
         ctrl_q <= wb_dat_i[3:0];
      end else if (wr_lo && hit_preset) begin
         preset_q <= wb_dat_i[3:0];
      end
   end

   // bus reset also clears the counter
   assign ctl.rst_n = ctrl_q[PC4_B_RST_N] & !rst_i;
   assign ctl.load_n = ctrl_q[PC4_B_LOAD_N];
   assign ctl.en_p = ctrl_q[PC4_B_EN_P];
   assign ctl.en_t = ctrl_q[PC4_B_EN_T];
   assign ctl.preset = preset_q;

   pc4_core #(.RST_MODE(RST_MODE)) u_core (
      .clk_i(clk_i),
      .ctl(ctl)
   );

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign count_o = ctl.count;
   assign carry_o = ctl.carry;

   chk_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   chk_ack_req: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   chk_carry_pin: assert property (@(posedge clk_i)
      carry_o == (ctrl_q[PC4_B_EN_T] && count_o == PC4_MAX))
      else $error("carry pin wrong");
   cov_wr: cover property (@(posedge clk_i) wb_ack_o && wb_we_i);
endmodule
`default_nettype wire

// ### rtl/pc4_pkg.sv
/*
 * constants for the presettable four bit counter: register map, fields,
 * reset values and build variants.
 * assumes a classic wishbone master with 32-bit data on a 10 MHz clock.
 */
`default_nettype none
package pc4_pkg;
   // count width and terminal state
   localparam int PC4_W = 4;
   localparam logic [3:0] PC4_MAX = 4'hF;
   localparam logic [3:0] PC4_ZERO = 4'h0;
   // register byte addresses
   localparam logic [7:0] PC4_ADR_CTRL = 8'h00;
   localparam logic [7:0] PC4_ADR_PRESET = 8'h04;
   localparam logic [7:0] PC4_ADR_COUNT = 8'h08;
   localparam logic [7:0] PC4_ADR_STAT = 8'h0C;
   // control register bit positions
   localparam int PC4_B_RST_N = 0;
   localparam int PC4_B_LOAD_N = 1;
   localparam int PC4_B_EN_P = 2;
   localparam int PC4_B_EN_T = 3;
   localparam logic [3:0] PC4_CTRL_RST = 4'hF;
   // status register bit positions
   localparam int PC4_B_CARRY = 0;
   localparam int PC4_B_ASYNC = 1;
   // reset variants
   typedef enum logic {PC4_RST_ASYNC, PC4_RST_SYNC} pc4_rst_mode_t;
   // slave answer states
   typedef enum {PC4_BUS_IDLE, PC4_BUS_ACK} pc4_bus_st_t;
endpackage
`default_nettype wire

// ### rtl/pc4_ctl_if.sv
/*
 * interface carrying counter controls from the bus slave to the core.
 * assumes both ends run on one clock.
 */
`default_nettype none
interface pc4_ctl_if;
   logic rst_n;
   logic load_n;
   logic en_p;
   logic en_t;
   logic [3:0] preset;
   logic [3:0] count;
   logic carry;
   modport slave (output rst_n, load_n, en_p, en_t, preset,
                  input count, carry);
   modport core (input rst_n, load_n, en_p, en_t, preset,
                 output count, carry);
endinterface
`default_nettype wire

// ### rtl/pc4_core.sv
/*
 * four bit presettable counter core with carry out.
 * assumes controls arrive from logic on clk_i; reset variant is fixed
 * at build time.
 */
`default_nettype none
module pc4_core
   import pc4_pkg::*;
#(
   parameter pc4_rst_mode_t RST_MODE = PC4_RST_SYNC
) (
   input wire logic clk_i, // system clock
   pc4_ctl_if.core ctl // controls and count
);
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic cnt_en;

   assign cnt_en = ctl.en_p & ctl.en_t & ctl.load_n;

   // load over count, load, wrap, hold
   assign cnt_d = !ctl.load_n ? ctl.preset :
                  cnt_en ? 4'(cnt_q + 4'h1) : cnt_q;

   generate
      if (RST_MODE == PC4_RST_ASYNC) begin : g_async
         always_ff @(posedge clk_i or negedge ctl.rst_n) begin
            if (!ctl.rst_n) begin
               cnt_q <= PC4_ZERO;
            end else begin
               cnt_q <= cnt_d;
            end
         end
      end else begin : g_sync
         // clear on the edge, reset wins
         always_ff @(posedge clk_i) begin
            if (!ctl.rst_n) begin
               cnt_q <= PC4_ZERO;
            end else begin
               cnt_q <= cnt_d;
            end
         end
      end
   endgenerate

   // count out, carry equation, trickle gates carry
   assign ctl.count = cnt_q;
   assign ctl.carry = ctl.en_t & (&cnt_q);

   chk_count_step: assert property (@(posedge clk_i)
      ctl.rst_n && $past(ctl.rst_n) && $past(cnt_en)
      |-> cnt_q == 4'($past(cnt_q) + 4'h1))
      else $error("count did not step");
   chk_load_wins: assert property (@(posedge clk_i)
      ctl.rst_n && $past(ctl.rst_n) && !$past(ctl.load_n)
      |-> cnt_q == $past(ctl.preset))
      else $error("load not taken");
   chk_hold_idle: assert property (@(posedge clk_i)
      ctl.rst_n && $past(ctl.rst_n) && $past(ctl.load_n)
      && !$past(cnt_en) |-> $stable(cnt_q))
      else $error("count moved while idle");
   chk_carry_max: assert property (@(posedge clk_i)
      ctl.carry == (ctl.en_t && cnt_q == PC4_MAX))
      else $error("carry wrong");
   chk_carry_gate: assert property (@(posedge clk_i)
      !ctl.en_t |-> !ctl.carry)
      else $error("carry high with trickle low");
   chk_wrap_zero: assert property (@(posedge clk_i)
      ctl.rst_n && $past(ctl.rst_n) && $past(cnt_en)
      && $past(cnt_q) == PC4_MAX |-> cnt_q == PC4_ZERO)
      else $error("no wrap to zero");
   chk_reset_clear: assert property (@(posedge clk_i)
      !$past(ctl.rst_n) |-> cnt_q == PC4_ZERO)
      else $error("reset did not clear");
   cov_wrap: cover property (@(posedge clk_i)
      cnt_en && cnt_q == PC4_MAX ##1 cnt_q == PC4_ZERO);
   cov_load: cover property (@(posedge clk_i) !ctl.load_n ##1 ctl.load_n);
   cov_carry: cover property (@(posedge clk_i) ctl.carry);
endmodule
`default_nettype wire

// ### bench/pc4_next_stage.sv
/* next cascaded counter stage, enabled by the lower carry.
   assumes one shared clock and a synchronous high reset. */
`default_nettype none
module pc4_next_stage
   import pc4_pkg::*;
(
   input wire logic clk_i, // shared clock
   input wire logic rst_i, // sync reset, high
   input wire logic carry_i, // lower stage carry
   output logic [3:0] count_o // upper stage count
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= PC4_ZERO;
      end else if (carry_i) begin
         count_o <= count_o + 4'h1;
      end
   end
endmodule
`default_nettype wire

// ### bench/pc4_top_tb_top.sv
/* self-checking bench for the bus counter and a next stage.
   assumes the default synchronous reset variant on a 10 MHz clock. */
`default_nettype none
module pc4_top_tb_top
   import pc4_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_i, rst_i, cyc, stb, we, wb_ack_o, carry_o;
   logic [7:0] adr;
   logic [3:0] sel, count_o, next_count, v, p;
   logic [31:0] wdat, wb_dat_o, q;
   int err_count, compares;
   pc4_top i_pc4_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .count_o(count_o), .carry_o(carry_o));
   pc4_next_stage i_pc4_next_stage (.clk_i(clk_i), .rst_i(rst_i),
      .carry_i(carry_o), .count_o(next_count));
   // clock of 100 ns period
   initial begin
      clk_i = 1'h0;
      forever #50 clk_i = ~clk_i;
   end
   task end_sim;
      $display("err_count %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask
   // one classic cycle, held until ack is sampled on a rising edge
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (wb_ack_o !== 1'h1) begin
         @(posedge clk_i);
      end
      q = wb_dat_o;
      chk({31'h0, wb_ack_o}, 32'h1);
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask
   task t_load;
      xfer(1'h0, PC4_ADR_CTRL, 32'h0);
      chk(q, 32'hF);
      xfer(1'h1, PC4_ADR_PRESET, 32'hC);
      xfer(1'h1, PC4_ADR_CTRL, 32'hD);
      repeat (3) @(negedge clk_i);
      chk(count_o, 32'hC);
      xfer(1'h1, PC4_ADR_CTRL, 32'hB);
      repeat (3) @(negedge clk_i);
      chk(count_o, 32'hC);
      chk(carry_o, 32'h0);
      xfer(1'h0, PC4_ADR_COUNT, 32'h0);
      chk(q, 32'hC);
   endtask
   task t_count;
      xfer(1'h1, PC4_ADR_CTRL, 32'hF);
      @(negedge clk_i);
      v = count_o;
      p = next_count;
      for (int i = 0; i < 6; i++) begin
         @(negedge clk_i);
         v = v + 4'h1;
         chk(count_o, v);
         chk(carry_o, v == 4'hF);
      end
      chk(next_count, 4'(p + 4'h1));
   endtask
   task t_trickle;
      xfer(1'h1, PC4_ADR_PRESET, 32'hF);
      xfer(1'h1, PC4_ADR_CTRL, 32'h5);
      repeat (2) @(negedge clk_i);
      chk(count_o, 32'hF);
      chk(carry_o, 32'h0);
      xfer(1'h1, PC4_ADR_CTRL, 32'hB);
      @(negedge clk_i);
      chk(carry_o, 32'h1);
      xfer(1'h0, PC4_ADR_STAT, 32'h0);
      chk(q, 32'h1);
   endtask
   task t_rst;
      xfer(1'h1, PC4_ADR_CTRL, 32'h0);
      repeat (2) @(negedge clk_i);
      chk(count_o, 32'h0);
      xfer(1'h0, 8'h10, 32'h0);
      chk(q, 32'h0);
   endtask
   // watchdog against a hung handshake
   initial begin
      repeat (2000) @(posedge clk_i);
      err_count++;
      end_sim;
   end
   initial begin
      rst_i = 1'h1;
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hF;
      err_count = 0;
      compares = 0;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'h0;
      @(negedge clk_i);
      chk(count_o, 32'h0);
      t_load;
      t_count;
      t_trickle;
      t_rst;
      end_sim;
   end
endmodule
`default_nettype wire
